// file: bench/acci2c_props.sv
// assertion checker on the wires between controller and target
`timescale 1ns/1ps
module acci2c_props (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic serial_clock_pin,
  input wire logic serial_data_pin,
  input wire logic sda_tgt_oe,
  input wire logic sda_ctl_oe,
  input wire logic chip_select_pin
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  ack_edge_a: assert property ($changed(sda_tgt_oe) |-> !serial_clock_pin)
    else $error("target moved data while clock high");
  ack_hold_a: assert property ($rose(serial_clock_pin) && sda_tgt_oe |=> sda_tgt_oe [*8])
    else $error("target ack not held through clock high");
  ack_release_a: assert property ($fell(serial_clock_pin) && sda_tgt_oe |-> ##[1:8] !sda_tgt_oe)
    else $error("target kept data low after ack");
  ack_alone_a: assert property (sda_tgt_oe |-> !sda_ctl_oe)
    else $error("controller pulled data during ack");
  stop_free_a: assert property ($rose(serial_data_pin) && serial_clock_pin |-> !sda_tgt_oe)
    else $error("target held data at stop");
  start_free_a: assert property ($fell(serial_data_pin) && serial_clock_pin |-> !sda_tgt_oe)
    else $error("target made a start");
  clk_high_a: assert property ($rose(serial_clock_pin) |-> serial_clock_pin [*8])
    else $error("clock high period too short");
  spi_quiet_a: assert property ($rose(chip_select_pin) |=> !sda_tgt_oe [*8])
    else $error("target answered after chip select rise");
  ////////////////////////////////////////
  cover property ($rose(sda_tgt_oe));
  cover property ($fell(serial_data_pin) && serial_clock_pin);
  cover property ($rose(serial_data_pin) && serial_clock_pin);
  cover property ($rose(chip_select_pin));
endmodule

// file: bench/test_sensor_i2c_target_port.sv
// bench: controller and target joined, plus a bench-driven second target
`timescale 1ns/1ps
module test_sensor_i2c_target_port;
  import acci2c_pkg::*;
  logic       mclk = 1'b0;
  logic       rst_b = 1'b0;
  logic       req_valid = 1'b0;
  logic [6:0] req_dev = 7'h00;
  logic [7:0] req_reg = 8'h00;
  logic [7:0] req_data = 8'h00;
  logic       req_low_power = 1'b0;
  logic       req_ready_ff, done_ff, nack_ff, stb1, stb2, busy2, spi2;
  logic [7:0] wa1, wd1, wa2, wd2, la1, ld1, la2, ld2;
  int         mismatches = 0;
  int         compares = 0;
  int         n1 = 0;
  int         n2 = 0;
  acci2c_if   b1();
  acci2c_if   b2();
  always #2 mclk = ~mclk;
  ////////////////////////////////////////
  acci2c_ctrl #(.HALF_CYC(8), .IDLE_PERF_CYC(20), .IDLE_LP_CYC(40)) u_acci2c_ctrl (.mclk(mclk),
    .rst_b(rst_b), .bus(b1), .req_valid(req_valid), .req_dev(req_dev), .req_reg(req_reg),
    .req_data(req_data), .req_low_power(req_low_power), .req_ready_ff(req_ready_ff),
    .done_ff(done_ff), .nack_ff(nack_ff));
  acci2c_target u_acci2c_target (.mclk(mclk), .rst_b(rst_b), .bus(b1), .wr_stb_ff(stb1),
    .wr_addr_ff(wa1), .wr_data_ff(wd1), .busy_ff(), .spi_mode_ff());
  acci2c_target u_acci2c_target2 (.mclk(mclk), .rst_b(rst_b), .bus(b2), .wr_stb_ff(stb2),
    .wr_addr_ff(wa2), .wr_data_ff(wd2), .busy_ff(busy2), .spi_mode_ff(spi2));
  acci2c_props u_acci2c_props (.mclk(mclk), .rst_b(rst_b),
    .serial_clock_pin(b1.serial_clock_pin), .serial_data_pin(b1.serial_data_pin),
    .sda_tgt_oe(b1.sda_tgt_oe), .sda_ctl_oe(b1.sda_ctl_oe),
    .chip_select_pin(b1.chip_select_pin));
  // stores are counted so that a refused frame shows as a missing count
  // sampled mid-cycle so the one-cycle strobe is seen settled
  always @(negedge mclk)
  begin
    if (stb1 === 1'b1)
    begin
      la1 = wa1;
      ld1 = wd1;
      n1++;
    end
    if (stb2 === 1'b1)
    begin
      la2 = wa2;
      ld2 = wd2;
      n2++;
    end
  end
  ////////////////////////////////////////
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic ok, input string what);
    compares++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  task automatic wr1(input logic [6:0] d, input logic [7:0] r, v, input logic lp, output int t);
    int n;
    @(negedge mclk);
    {req_dev, req_reg, req_data, req_low_power} = {d, r, v, lp};
    req_valid = 1'b1;
    n = 0;
    while (req_ready_ff !== 1'b1 && n < 100)
    begin
      @(negedge mclk);
      n++;
    end
    @(negedge mclk);
    req_valid = 1'b0;
    t = 0;
    while (done_ff !== 1'b1 && t < 4000)
    begin
      @(negedge mclk);
      t++;
    end
    if (t >= 4000 || n >= 100)
    begin
      mismatches++;
      $display("unexpected at %0t: request timed out", $time);
      complete_run();
    end
  endtask
  // one phase of the bench-made link clock: 4 mclk, a 64 ns period overall
  task automatic ph;
    repeat (4) @(negedge mclk);
  endtask
  task automatic bb(input logic v, output logic s);
    b2.scl_oe = 1'b1;
    ph();
    b2.sda_ctl_oe = !v;
    ph();
    b2.scl_oe = 1'b0;
    ph();
    s = b2.serial_data_pin;
    ph();
  endtask
  task automatic stop2;
    b2.scl_oe = 1'b1;
    ph();
    b2.sda_ctl_oe = 1'b1;
    ph();
    b2.scl_oe = 1'b0;
    ph();
    b2.sda_ctl_oe = 1'b0;
    ph();
  endtask
  task automatic byt(input logic [7:0] b, input logic exp);
    logic s;
    for (int i = 7; i >= 0; i--)
      bb(b[i], s);
    bb(1'b1, s);
    check(s === !exp, "acknowledge");
  endtask
  task automatic frame2(input logic [7:0] a, input logic [7:0] q[$], input logic exp);
    b2.sda_ctl_oe = 1'b1;
    ph();
    byt(a, exp);
    foreach (q[i])
      byt(q[i], exp);
    stop2();
  endtask
  ////////////////////////////////////////
  initial
  begin
    int t0;
    int t1;
    {b1.chip_select_pin, b1.address_select_pin, b2.chip_select_pin} = 3'h0;
    {b2.address_select_pin, b2.scl_o, b2.scl_oe, b2.sda_ctl_o, b2.sda_ctl_oe} = 5'h00;
    repeat (6) @(negedge mclk);
    rst_b = 1'b1;
    wr1(7'h18, 8'h41, 8'h01, 1'b0, t0);
    check(nack_ff === 1'b0 && la1 === 8'h41 && ld1 === 8'h01 && n1 == 1, "write");
    wr1(7'h18, 8'h42, 8'h02, 1'b1, t1);
    check(t1 - t0 == 20, "low power idle");
    wr1(7'h19, 8'h43, 8'h03, 1'b0, t0);
    check(nack_ff === 1'b1 && n1 == 2, "mismatch taken");
    b1.address_select_pin = 1'b1;
    wr1(7'h19, 8'h44, 8'h04, 1'b0, t0);
    check(nack_ff === 1'b0 && la1 === 8'h44 && ld1 === 8'h04 && n1 == 3, "strap");
    $display("test controller writes done");
    frame2(8'h30, {8'hfe, 8'ha1, 8'ha2, 8'ha3}, 1'b1);
    check(n2 == 3 && la2 === 8'h00 && ld2 === 8'ha3, "increment");
    frame2(8'h30, {8'h5e, 8'hb1, 8'hb2}, 1'b1);
    check(n2 == 5 && la2 === 8'h5e && ld2 === 8'hb2, "trap");
    frame2(8'h32, {8'h10, 8'h11}, 1'b0);
    frame2(8'h31, {8'h10}, 1'b0);
    frame2(8'hf0, {8'h10}, 1'b0);
    check(n2 == 5, "refused frame stored");
    $display("test multi byte and refusals done");
    b2.sda_ctl_oe = 1'b1;
    ph();
    check(busy2 === 1'b1, "start");
    b2.sda_ctl_oe = 1'b0;
    ph();
    check(busy2 === 1'b1, "bare stop taken");
    stop2();
    check(busy2 === 1'b0, "stop");
    b2.chip_select_pin = 1'b1;
    b1.chip_select_pin = 1'b1;
    ph();
    frame2(8'h30, {8'h01}, 1'b0);
    check(spi2 === 1'b1 && n2 == 5, "chip select");
    wr1(7'h18, 8'h45, 8'h05, 1'b0, t0);
    check(nack_ff === 1'b1 && n1 == 3, "chip select link");
    $display("test framing and chip select done");
    complete_run();
  end
endmodule

// file: rtl/acci2c_ctrl.sv
// controller end: drives scl by a divider and performs register write transfers
`timescale 1ns/1ps
module acci2c_ctrl
  import acci2c_pkg::*;
#(
  parameter int HALF_CYC = ACCI2C_HALF_CYC,
  parameter int IDLE_PERF_CYC = ACCI2C_IDLE_PERF_CYC,
  parameter int IDLE_LP_CYC   = ACCI2C_IDLE_LP_CYC
)(
  input  wire logic       mclk,
  input  wire logic       rst_b,
  acci2c_if.controller    bus,
  input  wire logic       req_valid,
  input  wire logic [6:0] req_dev,
  input  wire logic [7:0] req_reg,
  input  wire logic [7:0] req_data,
  input  wire logic       req_low_power,
  output logic            req_ready_ff,
  output logic            done_ff,
  output logic            nack_ff
);
  typedef enum logic [5:0] {
    ACC_C_IDLE  = 6'h01,
    ACC_C_START = 6'h02,
    ACC_C_BYTE  = 6'h04,
    ACC_C_STOP  = 6'h08,
    ACC_C_WAIT  = 6'h10,
    ACC_C_DONE  = 6'h20
  } acc_cstate_t;

  acc_cstate_t st_ff;
  logic [19:0] tick_ff;
  logic [19:0] idle_ff;
  logic [1:0]  ph_ff;
  logic [3:0]  bit_ff;
  logic [1:0]  byte_ff;
  logic [23:0] frame_ff;
  logic        scl_ff, sda_ff, sda_s0_ff, sda_s1_ff;

  wire tick = (tick_ff == 20'(HALF_CYC - 1));
  wire [7:0] cur_byte = frame_ff[23:16];

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_ff        <= ACC_C_IDLE;
      tick_ff      <= 20'h0;
      idle_ff      <= 20'h0;
      ph_ff        <= 2'h0;
      bit_ff       <= 4'h0;
      byte_ff      <= 2'h0;
      frame_ff     <= 24'h0;
      scl_ff       <= 1'b1;
      sda_ff       <= 1'b1;
      sda_s0_ff    <= 1'b1;
      sda_s1_ff    <= 1'b1;
      req_ready_ff <= 1'b0;
      done_ff      <= 1'b0;
      nack_ff      <= 1'b0;
    end
    else
    begin
      sda_s0_ff <= bus.serial_data_pin;
      sda_s1_ff <= sda_s0_ff;
      done_ff   <= 1'b0;
      tick_ff   <= tick ? 20'h0 : tick_ff + 20'h1;
      unique case (st_ff)
        ACC_C_IDLE:
        begin
          req_ready_ff <= 1'b1;
          if (req_valid && req_ready_ff)
          begin
            req_ready_ff <= 1'b0;
            frame_ff <= {req_dev, 1'b0, req_reg, req_data};
            idle_ff  <= req_low_power ? 20'(IDLE_LP_CYC) : 20'(IDLE_PERF_CYC);
            st_ff    <= ACC_C_START;
            ph_ff    <= 2'h0;
            nack_ff  <= 1'b0;
            // restart the divider so frames of equal byte count and idle setting have the same length
            tick_ff  <= 20'h0;
          end
        end
        ACC_C_START: if (tick)
        begin
          sda_ff <= 1'b0;
          st_ff   <= ACC_C_BYTE;
          bit_ff  <= 4'h0;
          byte_ff <= 2'h0;
          ph_ff   <= 2'h0;
        end
        ACC_C_BYTE: if (tick)
        begin
          ph_ff <= ph_ff + 2'h1;
          if (ph_ff == 2'h0)
          begin
            scl_ff <= 1'b0;
            // let go of data as the eighth clock falls, before the target pulls it
            if (bit_ff == ACCI2C_BIT_ACK)
              sda_ff <= 1'b1;
          end
          else if (ph_ff == 2'h1)
            sda_ff <= (bit_ff == ACCI2C_BIT_ACK) ? 1'b1 : cur_byte[3'(7 - bit_ff)];
          else if (ph_ff == 2'h2)
            scl_ff <= 1'b1;
          else
          begin
            if (bit_ff == ACCI2C_BIT_ACK)
            begin
              bit_ff <= 4'h0;
              frame_ff <= {frame_ff[15:0], 8'h00};
              byte_ff <= byte_ff + 2'h1;
              if (sda_s1_ff)
              begin
                nack_ff <= 1'b1;
                st_ff <= ACC_C_STOP;
              end
              else if (byte_ff == 2'h2)
                st_ff <= ACC_C_STOP;
            end
            else
              bit_ff <= bit_ff + 4'h1;
          end
        end
        ACC_C_STOP: if (tick)
        begin
          ph_ff <= ph_ff + 2'h1;
          if (ph_ff == 2'h0) scl_ff <= 1'b0;
          else if (ph_ff == 2'h1) sda_ff <= 1'b0;
          else if (ph_ff == 2'h2) scl_ff <= 1'b1;
          else
          begin
            sda_ff <= 1'b1;
            st_ff  <= ACC_C_WAIT;
          end
        end
        ACC_C_WAIT:
        begin
          idle_ff <= idle_ff - 20'h1;
          if (idle_ff == 20'h0) st_ff <= ACC_C_DONE;
        end
        ACC_C_DONE:
        begin
          done_ff <= 1'b1;
          st_ff <= ACC_C_IDLE;
        end
        default: st_ff <= ACC_C_IDLE;
      endcase
    end
  end

  assign bus.scl_o      = 1'b0;
  assign bus.scl_oe     = !scl_ff;
  assign bus.sda_ctl_o  = 1'b0;
  assign bus.sda_ctl_oe = !sda_ff;
endmodule

// file: rtl/acci2c_if.sv
// i2c bus wires between sensor target and controller, open drain resolved here
`timescale 1ns/1ps
interface acci2c_if;
  logic scl_o;
  logic scl_oe;
  logic sda_tgt_oe;
  logic sda_ctl_oe;
  logic sda_tgt_o;
  logic sda_ctl_o;
  logic chip_select_pin;
  logic address_select_pin;
  wire  serial_clock_pin = !(scl_oe && !scl_o);
  wire  serial_data_pin  = !((sda_tgt_oe && !sda_tgt_o) || (sda_ctl_oe && !sda_ctl_o));
  modport target (input serial_clock_pin, input serial_data_pin, input chip_select_pin,
                  input address_select_pin, output sda_tgt_o, output sda_tgt_oe);
  modport controller (input serial_clock_pin, input serial_data_pin, output scl_o,
                      output scl_oe, output sda_ctl_o, output sda_ctl_oe);
endinterface

// file: rtl/acci2c_pkg.sv
// constants shared by both ends of the sensor i2c target port
package acci2c_pkg;
  localparam logic [6:0] ACCI2C_ADDR_BASE   = 7'h18;
  localparam logic [6:0] ACCI2C_ADDR_ALT    = 7'h19;
  localparam int         ACCI2C_CLK_MHZ     = 250;
  localparam int         ACCI2C_SCL_KHZ     = 1000;
  // quarter period of the controller's divided bus clock (one phase), in mclk cycles
  localparam int         ACCI2C_HALF_CYC    = (ACCI2C_CLK_MHZ * 1000) / (ACCI2C_SCL_KHZ * 2);
  localparam int         ACCI2C_IDLE_PERF_US = 2;
  localparam int         ACCI2C_IDLE_LP_US   = 450;
  localparam int         ACCI2C_IDLE_PERF_CYC = ACCI2C_IDLE_PERF_US * ACCI2C_CLK_MHZ;
  localparam int         ACCI2C_IDLE_LP_CYC   = ACCI2C_IDLE_LP_US * ACCI2C_CLK_MHZ;
  localparam logic [3:0] ACCI2C_BIT_ACK     = 4'h8;
  localparam logic [3:0] ACCI2C_BIT_LAST    = 4'h7;
  localparam logic [7:0] ACCI2C_REG_ZERO    = 8'h00;
  localparam int         ACCI2C_BYTE_W      = 8;
endpackage

// file: rtl/acci2c_target.sv
// sensor-side i2c target: start/stop, address match, target_acknowledge, register writes
`timescale 1ns/1ps
module acci2c_target
  import acci2c_pkg::*;
#(
  parameter logic [7:0] TRAP_LO = 8'h5e,
  parameter logic [7:0] TRAP_HI = 8'h5e
)(
  input  wire logic       mclk,
  input  wire logic       rst_b,
  acci2c_if.target        bus,
  output logic            wr_stb_ff,
  output logic [7:0]      wr_addr_ff,
  output logic [7:0]      wr_data_ff,
  output logic            busy_ff,
  output logic            spi_mode_ff
);
  typedef enum logic [4:0] {
    ACC_IDLE = 5'h01,
    ACC_ADDR = 5'h02,
    ACC_REGA = 5'h04,
    ACC_DATA = 5'h08,
    ACC_SKIP = 5'h10
  } acc_state_t;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] scl_sync_ff, sda_sync_ff, cs_sync_ff, sel_sync_ff;
  logic       scl_d_ff, sda_d_ff, cs_d_ff;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      cs_sync_ff  <= 2'h3;
      sel_sync_ff <= 2'h0;
      scl_d_ff    <= 1'b1;
      sda_d_ff    <= 1'b1;
      cs_d_ff     <= 1'b1;
    end
    else
    begin
      scl_sync_ff <= {scl_sync_ff[0], bus.serial_clock_pin};
      sda_sync_ff <= {sda_sync_ff[0], bus.serial_data_pin};
      cs_sync_ff  <= {cs_sync_ff[0], bus.chip_select_pin};
      sel_sync_ff <= {sel_sync_ff[0], bus.address_select_pin};
      scl_d_ff    <= scl_sync_ff[1];
      sda_d_ff    <= sda_sync_ff[1];
      cs_d_ff     <= cs_sync_ff[1];
    end
  end

  wire scl      = scl_sync_ff[1];
  wire sda      = sda_sync_ff[1];
  wire scl_rise = scl && !scl_d_ff;
  wire scl_fall = !scl && scl_d_ff;
  // edges on data are only conditions while the clock sat high in both samples
  wire start_c  = scl && scl_d_ff && !sda && sda_d_ff;
  wire stop_c   = scl && scl_d_ff && sda && !sda_d_ff;
  wire cs_rise  = cs_sync_ff[1] && !cs_d_ff;

  //////////////////////////////////////////////////////////////////////////////
  // protocol state
  acc_state_t state_ff, nxt_state;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] reg_ptr_ff;
  logic       ack_ff;
  logic       scl_seen_ff;
  logic [6:0] my_addr_ff;

  // strap is only read as a synchronised level, never under reset
  wire [6:0] sel_addr  = sel_sync_ff[1] ? ACCI2C_ADDR_ALT : ACCI2C_ADDR_BASE;
  wire [7:0] byte_in   = {shift_ff[6:0], sda};
  wire [3:0] ack_tail  = ACCI2C_BIT_ACK + 4'h1;
  wire       byte_done = scl_rise && (bit_cnt_ff == ACCI2C_BIT_LAST);
  wire       ack_end   = scl_fall && (bit_cnt_ff == ack_tail);
  // a 7-bit address plus a zero direction bit only; 10-bit prefixes never match
  wire       addr_hit  = (byte_in[7:1] == my_addr_ff) && !byte_in[0];
  wire       trapped   = (reg_ptr_ff >= TRAP_LO) && (reg_ptr_ff <= TRAP_HI);
  wire       stop_ok   = stop_c && scl_seen_ff;
  wire       active    = !spi_mode_ff;

  always_comb
  begin
    nxt_state = state_ff;
    if (!active || stop_ok)
      nxt_state = ACC_IDLE;
    else if (start_c)
      nxt_state = ACC_ADDR;
    else if (byte_done)
    begin
      unique case (state_ff)
        ACC_ADDR: nxt_state = addr_hit ? ACC_REGA : ACC_SKIP;
        ACC_REGA: nxt_state = ACC_DATA;
        ACC_DATA: nxt_state = ACC_DATA;
        ACC_IDLE: nxt_state = ACC_IDLE;
        ACC_SKIP: nxt_state = ACC_SKIP;
        default:  nxt_state = ACC_IDLE;
      endcase
    end
  end

  // bit counter: 0..7 data, 8 ack low phase, 9 ack high; edges sampled fine up to 1 MHz
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff    <= ACC_IDLE;
      bit_cnt_ff  <= 4'h0;
      shift_ff    <= ACCI2C_REG_ZERO;
      reg_ptr_ff  <= ACCI2C_REG_ZERO;
      ack_ff      <= 1'b0;
      scl_seen_ff <= 1'b0;
      busy_ff     <= 1'b0;
      spi_mode_ff <= 1'b0;
      my_addr_ff  <= ACCI2C_ADDR_BASE;
      wr_stb_ff   <= 1'b0;
      wr_addr_ff  <= ACCI2C_REG_ZERO;
      wr_data_ff  <= ACCI2C_REG_ZERO;
    end
    else
    begin
      state_ff  <= nxt_state;
      wr_stb_ff <= 1'b0;
      if (cs_rise)
        spi_mode_ff <= 1'b1;
      if (start_c || stop_ok)
        busy_ff <= start_c;
      if (start_c)
      begin
        my_addr_ff  <= sel_addr;
        bit_cnt_ff  <= 4'h0;
        scl_seen_ff <= 1'b0;
        ack_ff      <= 1'b0;
      end
      else
      begin
        if (scl_fall)
          scl_seen_ff <= 1'b1;
        // the ack clock's own rise must not be taken as a data bit
        if (scl_rise && bit_cnt_ff <= ACCI2C_BIT_LAST)
          shift_ff <= byte_in;
        if (ack_end)
          bit_cnt_ff <= 4'h0;
        else if (scl_rise && bit_cnt_ff != ack_tail)
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
        // pull low from the fall that ends bit 7 to the fall that ends the ack clock
        if (ack_end)
          ack_ff <= 1'b0;
        if (byte_done && active)
        begin
          unique case (state_ff)
            ACC_ADDR: ack_ff <= addr_hit;
            ACC_REGA:
            begin
              ack_ff     <= 1'b1;
              reg_ptr_ff <= byte_in;
            end
            ACC_DATA:
            begin
              ack_ff     <= 1'b1;
              wr_stb_ff  <= 1'b1;
              wr_addr_ff <= reg_ptr_ff;
              wr_data_ff <= byte_in;
              if (!trapped)
                reg_ptr_ff <= reg_ptr_ff + 8'h01;
            end
            default: ack_ff <= 1'b0;
          endcase
        end
      end
      if (stop_ok || !active)
        ack_ff <= 1'b0;
    end
  end

  // the bit count is 7 when byte_done fires, so ack_ff rises only after that scl rise;
  // drive waits for the following fall so the controller's bit 7 is not disturbed
  logic drive_ff;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      drive_ff <= 1'b0;
    else if (ack_end || start_c || stop_ok || !active)
      drive_ff <= 1'b0;
    else if (scl_fall && ack_ff && bit_cnt_ff == ACCI2C_BIT_ACK)
      drive_ff <= 1'b1;
  end

  assign bus.sda_tgt_o  = 1'b0;
  assign bus.sda_tgt_oe = drive_ff;
endmodule
